// file: src/fsst_pkg.sv
/*
 Package for the frame statistics and self-test register set: register
 offsets, reset values, self-test figures, serial framing and timing counts.
 Assumes a 25 MHz system clock on both ends.
*/
package fsst_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [6:0] ADDR_EXPOSURE_HIGH = 7'h07;
	localparam logic [6:0] ADDR_EXPOSURE_LOW = 7'h08;
	localparam logic [6:0] ADDR_PEAK_PIXEL = 7'h09;
	localparam logic [6:0] ADDR_PIXEL_TOTAL = 7'h0A;
	localparam logic [6:0] ADDR_LOWEST_PIXEL = 7'h0B;
	localparam logic [6:0] ADDR_RESULT0 = 7'h0C;
	localparam logic [6:0] ADDR_RESULT1 = 7'h0D;
	localparam logic [6:0] ADDR_RESULT2 = 7'h0E;
	localparam logic [6:0] ADDR_RESULT3 = 7'h0F;
	localparam logic [6:0] ADDR_DIAG_START = 7'h10;
	localparam int DIAG_RUN_ENABLE_BIT = 0;
	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_EXPOSURE_HIGH = 8'h00;
	localparam logic [7:0] RST_EXPOSURE_LOW = 8'h64;
	localparam logic [7:0] RST_PEAK_PIXEL = 8'hD0;
	localparam logic [7:0] RST_PIXEL_TOTAL = 8'h80;
	localparam logic [7:0] RST_LOWEST_PIXEL = 8'h00;
	localparam logic [7:0] RST_RESULT = 8'h00;
	// ==========================================================
	// Self-test pass signature
	localparam logic [7:0] PASS_RESULT0 = 8'h18;
	localparam logic [7:0] PASS_RESULT1 = 8'h44;
	localparam logic [7:0] PASS_RESULT2 = 8'h62;
	localparam logic [7:0] PASS_RESULT3 = 8'h47;
	// ==========================================================
	// Pixel statistics
	localparam logic [7:0] PIXEL_LEVEL_MAX = 8'hFE;
	localparam logic [7:0] PIXEL_TOTAL_MAX = 8'hA7;
	localparam int PIXEL_SUM_WIDTH = 18;
	localparam int PIXELS_PER_FRAME = 676;
	localparam logic [9:0] PIXEL_LAST_INDEX = 10'(PIXELS_PER_FRAME - 1);
	localparam logic [7:0] AVG_TARGET_LOW = 8'h50;
	localparam logic [7:0] AVG_TARGET_HIGH = 8'hB0;
	localparam logic [7:0] PEAK_SATURATION = 8'hF0;
	localparam logic [15:0] EXPOSURE_MIN = 16'h0010;
	localparam logic [15:0] EXPOSURE_MAX = 16'hFFF0;
	localparam logic [15:0] EXPOSURE_STEP = 16'h0008;
	// ==========================================================
	// Timing
	localparam int CLK_HZ = 25_000_000;
	localparam int SELFTEST_TIME_MS = 250;
	localparam int SELFTEST_CYCLES = (CLK_HZ / 1000) * SELFTEST_TIME_MS;
	localparam int SERIAL_DIVIDE = 8;
	localparam int SERIAL_BITS = 16;
	// First serial bit: 1 = write, 0 = read
	localparam int SERIAL_WRITE_BIT = 7;
endpackage

// file: src/fsst_link_if.sv
/*
 Four-wire serial link between the register set and its controller.
 Assumes the controller drives select, clock and data in; the device drives data out.
*/
`timescale 1ns/1ns
interface fsst_link_if;
	logic sel_b;
	logic sclk;
	logic mosi;
	logic miso;
	modport device (input sel_b, input sclk, input mosi, output miso);
	modport host (output sel_b, output sclk, output mosi, input miso);
endinterface

// file: src/fsst_device.sv
/*
 Device end: frame statistics, automatic exposure, self test and the serial
 register slave. Serial mode 3: data changes on falling clock, sampled rising.
 Assumes pixel levels arrive as a pixel-valid stream on the system clock, and
 that the link pins are asynchronous to clk_in.
*/
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ns
module fsst_device #(
	parameter int SELFTEST_CYCLES = fsst_pkg::SELFTEST_CYCLES
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	fsst_link_if.device link,
	input wire logic pixel_valid_in,
	input wire logic [7:0] pixel_level_in,
	output logic selftest_busy_out,
	output logic [15:0] exposure_out
);
	// ==========================================================
	// Link synchronisers: three stages, change taken when stages two and three agree
	logic [2:0] sel_sync_reg;
	logic [2:0] sclk_sync_reg;
	logic [2:0] mosi_sync_reg;
	logic sel_b_reg;
	logic sclk_reg;
	logic mosi_reg;
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			sel_sync_reg <= 3'h7;
			sclk_sync_reg <= 3'h7;
			mosi_sync_reg <= 3'h0;
		end else begin
			sel_sync_reg <= {sel_sync_reg[1:0], link.sel_b};
			sclk_sync_reg <= {sclk_sync_reg[1:0], link.sclk};
			mosi_sync_reg <= {mosi_sync_reg[1:0], link.mosi};
		end
	end
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			sel_b_reg <= 1'b1;
			sclk_reg <= 1'b1;
			mosi_reg <= 1'b0;
		end else begin
			if (sel_sync_reg[1] == sel_sync_reg[2])
				sel_b_reg <= sel_sync_reg[2];
			if (sclk_sync_reg[1] == sclk_sync_reg[2])
				sclk_reg <= sclk_sync_reg[2];
			if (mosi_sync_reg[1] == mosi_sync_reg[2])
				mosi_reg <= mosi_sync_reg[2];
		end
	end
	wire sclk_rise = sclk_sync_reg[2] & sclk_sync_reg[1] & ~sclk_reg;
	wire sclk_fall = ~sclk_sync_reg[2] & ~sclk_sync_reg[1] & sclk_reg;

	// ==========================================================
	// Frame statistics
	logic [9:0] pix_idx_reg;
	logic [17:0] sum_acc_reg;
	logic [7:0] max_acc_reg;
	logic [7:0] min_acc_reg;
	logic [7:0] peak_reg;
	logic [7:0] lowest_reg;
	logic [7:0] total_reg;
	logic frame_end_reg;
	logic [7:0] pix_clip;
	assign pix_clip = (pixel_level_in > fsst_pkg::PIXEL_LEVEL_MAX) ? fsst_pkg::PIXEL_LEVEL_MAX : pixel_level_in;
	wire last_pixel = pixel_valid_in && (pix_idx_reg == fsst_pkg::PIXEL_LAST_INDEX);
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			pix_idx_reg <= 10'h000;
			sum_acc_reg <= 18'h00000;
			max_acc_reg <= 8'h00;
			min_acc_reg <= fsst_pkg::PIXEL_LEVEL_MAX;
		end else if (pixel_valid_in) begin
			if (last_pixel) begin
				pix_idx_reg <= 10'h000;
				sum_acc_reg <= 18'h00000;
				max_acc_reg <= 8'h00;
				min_acc_reg <= fsst_pkg::PIXEL_LEVEL_MAX;
			end else begin
				pix_idx_reg <= pix_idx_reg + 10'h001;
				sum_acc_reg <= sum_acc_reg + {10'h000, pix_clip};
				max_acc_reg <= (pix_clip > max_acc_reg) ? pix_clip : max_acc_reg;
				min_acc_reg <= (pix_clip < min_acc_reg) ? pix_clip : min_acc_reg;
			end
		end
	end
	// Final pixel folded in as the whole set is latched in one edge
	logic [17:0] sum_final;
	logic [7:0] total_final;
	assign sum_final = sum_acc_reg + {10'h000, pix_clip};
	assign total_final = sum_final[17:10];
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			peak_reg <= fsst_pkg::RST_PEAK_PIXEL;
			lowest_reg <= fsst_pkg::RST_LOWEST_PIXEL;
			total_reg <= fsst_pkg::RST_PIXEL_TOTAL;
			frame_end_reg <= 1'b0;
		end else begin
			frame_end_reg <= last_pixel;
			if (last_pixel) begin
				peak_reg <= (pix_clip > max_acc_reg) ? pix_clip : max_acc_reg;
				lowest_reg <= (pix_clip < min_acc_reg) ? pix_clip : min_acc_reg;
				total_reg <= (total_final > fsst_pkg::PIXEL_TOTAL_MAX) ?
					fsst_pkg::PIXEL_TOTAL_MAX : total_final;
			end
		end
	end

	// ==========================================================
	// Automatic exposure, one step per frame
	logic [15:0] exposure_reg;
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			exposure_reg <= {fsst_pkg::RST_EXPOSURE_HIGH, fsst_pkg::RST_EXPOSURE_LOW};
		end else if (frame_end_reg) begin
			if ((peak_reg >= fsst_pkg::PEAK_SATURATION || total_reg > fsst_pkg::AVG_TARGET_HIGH)
				&& exposure_reg > fsst_pkg::EXPOSURE_MIN)
				exposure_reg <= exposure_reg - fsst_pkg::EXPOSURE_STEP;
			else if (total_reg < fsst_pkg::AVG_TARGET_LOW && peak_reg < fsst_pkg::PEAK_SATURATION
				&& exposure_reg < fsst_pkg::EXPOSURE_MAX)
				exposure_reg <= exposure_reg + fsst_pkg::EXPOSURE_STEP;
		end
	end
	assign exposure_out = exposure_reg;

	// ==========================================================
	// Serial slave: 8-bit command, 8-bit data
	logic [4:0] bit_cnt_reg;
	logic [7:0] shift_in_reg;
	logic [7:0] cmd_reg;
	logic [7:0] shift_out_reg;
	logic miso_reg;
	logic start_test;
	logic [7:0] exposure_low_hold_reg;
	logic [7:0] result_reg [4];

	function automatic logic [7:0] read_mux(input logic [6:0] addr);
		case (addr)
			fsst_pkg::ADDR_EXPOSURE_HIGH: read_mux = exposure_reg[15:8];
			fsst_pkg::ADDR_EXPOSURE_LOW: read_mux = exposure_low_hold_reg;
			fsst_pkg::ADDR_PEAK_PIXEL: read_mux = peak_reg;
			fsst_pkg::ADDR_PIXEL_TOTAL: read_mux = total_reg;
			fsst_pkg::ADDR_LOWEST_PIXEL: read_mux = lowest_reg;
			fsst_pkg::ADDR_RESULT0: read_mux = result_reg[0];
			fsst_pkg::ADDR_RESULT1: read_mux = result_reg[1];
			fsst_pkg::ADDR_RESULT2: read_mux = result_reg[2];
			fsst_pkg::ADDR_RESULT3: read_mux = result_reg[3];
			default: read_mux = 8'h00;
		endcase
	endfunction

	wire [7:0] shift_next = {shift_in_reg[6:0], mosi_reg};
	always_ff @(posedge clk_in) begin
		if (!rst_b_in || sel_b_reg) begin
			bit_cnt_reg <= 5'h00;
			shift_in_reg <= 8'h00;
			cmd_reg <= 8'h00;
		end else if (sclk_rise && bit_cnt_reg < 5'(fsst_pkg::SERIAL_BITS)) begin
			bit_cnt_reg <= bit_cnt_reg + 5'h01;
			shift_in_reg <= shift_next;
			if (bit_cnt_reg == 5'h07)
				cmd_reg <= shift_next;
		end
	end
	assign start_test = sclk_rise && !sel_b_reg && bit_cnt_reg == 5'h0F && cmd_reg[fsst_pkg::SERIAL_WRITE_BIT]
		&& cmd_reg[6:0] == fsst_pkg::ADDR_DIAG_START && shift_next[fsst_pkg::DIAG_RUN_ENABLE_BIT];

	// Low byte frozen when the high byte is read so the pair is coherent
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			exposure_low_hold_reg <= fsst_pkg::RST_EXPOSURE_LOW;
		end else if (sclk_rise && !sel_b_reg && bit_cnt_reg == 5'h07 && !shift_next[fsst_pkg::SERIAL_WRITE_BIT]
			&& shift_next[6:0] == fsst_pkg::ADDR_EXPOSURE_HIGH) begin
			exposure_low_hold_reg <= exposure_reg[7:0];
		end else if (sel_b_reg) begin
			exposure_low_hold_reg <= exposure_low_hold_reg;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			shift_out_reg <= 8'h00;
			miso_reg <= 1'b0;
		end else if (sel_b_reg) begin
			miso_reg <= 1'b0;
		end else if (sclk_fall && bit_cnt_reg == 5'h08) begin
			shift_out_reg <= {read_mux(cmd_reg[6:0]) << 1};
			miso_reg <= read_mux(cmd_reg[6:0]) >> 7 != 8'h00;
		end else if (sclk_fall && bit_cnt_reg > 5'h08) begin
			shift_out_reg <= {shift_out_reg[6:0], 1'b0};
			miso_reg <= shift_out_reg[7];
		end
	end
	assign link.miso = miso_reg;

	// ==========================================================
	// Self test
	logic [31:0] test_cnt_reg;
	logic busy_reg;
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			busy_reg <= 1'b0;
			test_cnt_reg <= 32'h00000000;
		end else if (start_test && !busy_reg) begin
			busy_reg <= 1'b1;
			test_cnt_reg <= 32'(SELFTEST_CYCLES - 1);
		end else if (busy_reg) begin
			if (test_cnt_reg == 32'h00000000)
				busy_reg <= 1'b0;
			else
				test_cnt_reg <= test_cnt_reg - 32'h00000001;
		end
	end
	assign selftest_busy_out = busy_reg;

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			for (int i = 0; i < 4; i++)
				result_reg[i] <= fsst_pkg::RST_RESULT;
		end else if (busy_reg && test_cnt_reg == 32'h00000000) begin
			result_reg[0] <= fsst_pkg::PASS_RESULT0;
			result_reg[1] <= fsst_pkg::PASS_RESULT1;
			result_reg[2] <= fsst_pkg::PASS_RESULT2;
			result_reg[3] <= fsst_pkg::PASS_RESULT3;
		end
	end
endmodule

// file: src/fsst_host.sv
/*
 Controller end: turns plain register reads and writes into 16-bit serial
 frames. Makes the link clock by dividing clk_in; samples data in through
 three flip-flops. Assumes a device in serial mode 3.
*/
`timescale 1ns/1ns
module fsst_host (
	input wire logic clk_in,
	input wire logic rst_b_in,
	fsst_link_if.host link,
	input wire logic [6:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	output logic busy_out,
	output logic done_out
);
	typedef enum logic [1:0] {
		FSST_IDLE = 2'b00,
		FSST_SHIFT = 2'b01,
		FSST_GAP = 2'b10
	} fsst_state_e;
	fsst_state_e state_reg;
	logic [15:0] tx_reg;
	logic [7:0] rx_reg;
	logic [4:0] bit_reg;
	logic [3:0] div_reg;
	logic sclk_reg;
	logic sel_b_reg;
	logic mosi_reg;
	logic [2:0] miso_sync_reg;
	logic miso_reg;
	logic is_read_reg;

	// ==========================================================
	// Data in: three stages, taken when two and three agree
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			miso_sync_reg <= 3'h0;
			miso_reg <= 1'b0;
		end else begin
			miso_sync_reg <= {miso_sync_reg[1:0], link.miso};
			if (miso_sync_reg[1] == miso_sync_reg[2])
				miso_reg <= miso_sync_reg[2];
		end
	end

	// ==========================================================
	// Frame sequencer; low half-period drives data, high half samples at its end
	// Orders are refused while a frame is in flight; device must not be touched
	// during its self test, so software watches the device, not this block
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			state_reg <= FSST_IDLE;
			tx_reg <= 16'h0000;
			rx_reg <= 8'h00;
			bit_reg <= 5'h00;
			div_reg <= 4'h0;
			sclk_reg <= 1'b1;
			sel_b_reg <= 1'b1;
			mosi_reg <= 1'b0;
			is_read_reg <= 1'b0;
			rdata_out <= 8'h00;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			case (state_reg)
				FSST_IDLE: begin
					if (wr_in || rd_in) begin
						// Exposure pair: read high then low as two orders back to back
						tx_reg <= {wr_in, addr_in, wr_in ? wdata_in : 8'h00};
						is_read_reg <= rd_in && !wr_in;
						sel_b_reg <= 1'b0;
						bit_reg <= 5'h00;
						div_reg <= 4'h0;
						state_reg <= FSST_SHIFT;
					end
				end
				FSST_SHIFT: begin
					div_reg <= div_reg + 4'h1;
					if (div_reg == 4'h0) begin
						sclk_reg <= 1'b0;
						mosi_reg <= tx_reg[15];
						tx_reg <= {tx_reg[14:0], 1'b0};
					end else if (div_reg == 4'(fsst_pkg::SERIAL_DIVIDE)) begin
						sclk_reg <= 1'b1;
					end else if (div_reg == 4'(2 * fsst_pkg::SERIAL_DIVIDE - 1)) begin
						// Answer needs eight clocks through both synchronisers, so sample late
						if (bit_reg >= 5'h08)
							rx_reg <= {rx_reg[6:0], miso_reg};
						div_reg <= 4'h0;
						bit_reg <= bit_reg + 5'h01;
						if (bit_reg == 5'(fsst_pkg::SERIAL_BITS - 1))
							state_reg <= FSST_GAP;
					end
				end
				FSST_GAP: begin
					sel_b_reg <= 1'b1;
					div_reg <= div_reg + 4'h1;
					if (div_reg == 4'(fsst_pkg::SERIAL_DIVIDE)) begin
						if (is_read_reg)
							rdata_out <= rx_reg;
						done_out <= 1'b1;
						state_reg <= FSST_IDLE;
					end
				end
				default: state_reg <= FSST_IDLE;
			endcase
		end
	end
	always_ff @(posedge clk_in) begin
		if (!rst_b_in)
			busy_out <= 1'b0;
		else
			busy_out <= (state_reg != FSST_IDLE) || wr_in || rd_in;
	end
	assign link.sel_b = sel_b_reg;
	assign link.sclk = sclk_reg;
	assign link.mosi = mosi_reg;
endmodule

// file: tb/fsst_link_chk_sva.sv
/*
 Checker on the serial link between the two ends, plus the self-test busy
 flag and the exposure value. Assumes the testbench instantiates it beside the link.
*/
`timescale 1ns/1ns
module fsst_link_chk #(
	parameter int SELFTEST_CYCLES = 50
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic sel_b,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic miso,
	input wire logic selftest_busy_out,
	input wire logic [15:0] exposure_out
);
	// ==========================================================
	// Helper counters
	logic sclk_q;
	logic [4:0] rise_cnt;
	int busy_cnt;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	always_ff @(posedge clk_in) begin
		sclk_q <= sclk;
	end
	always_ff @(posedge clk_in) begin
		if (!rst_b_in || sel_b) begin
			rise_cnt <= 5'h00;
		end else if (sclk && !sclk_q) begin
			rise_cnt <= rise_cnt + 5'h01;
		end
	end
	always_ff @(posedge clk_in) begin
		if (!rst_b_in || !selftest_busy_out) begin
			busy_cnt <= 0;
		end else begin
			busy_cnt <= busy_cnt + 1;
		end
	end
	// ==========================================================
	// Link framing
	sequence s_low8;
		(!sclk)[*8];
	endsequence
	sequence s_high8;
		sclk[*8];
	endsequence
	AST_SCLK_LOW: assert property ($fell(sclk) |-> s_low8)
		else $error("link clock low phase wrong");
	AST_SCLK_HIGH: assert property ($rose(sclk) |-> s_high8)
		else $error("link clock high phase wrong");
	AST_IDLE_HIGH: assert property (sel_b |-> sclk)
		else $error("link clock not idle high");
	AST_SEL_TO_CLK: assert property ($fell(sel_b) |=> $fell(sclk))
		else $error("first clock fall late");
	AST_FRAME_BITS: assert property ($rose(sel_b) |-> rise_cnt == 5'h10)
		else $error("frame not sixteen bits");
	AST_MOSI_HOLD: assert property ((!sel_b && !$past(sel_b) && sclk) |-> $stable(mosi))
		else $error("data out moved while clock high");
	AST_MISO_HOLD: assert property ((!sel_b && sclk && sclk_q) |-> $stable(miso))
		else $error("data in moved while clock high");
	AST_MISO_IDLE: assert property (sel_b[*6] |-> !miso)
		else $error("data in not low when deselected");
	// ==========================================================
	// Self test and exposure
	AST_TEST_LEN: assert property ($fell(selftest_busy_out) |-> busy_cnt == SELFTEST_CYCLES)
		else $error("self test length wrong");
	AST_TEST_QUIET: assert property (selftest_busy_out[*8] |-> sel_b)
		else $error("link used during self test");
	AST_EXP_STEP: assert property ($changed(exposure_out) |->
		(exposure_out == $past(exposure_out) + 16'h0008 || exposure_out == $past(exposure_out) - 16'h0008))
		else $error("exposure step wrong");
	AST_EXP_RANGE: assert property (exposure_out >= fsst_pkg::EXPOSURE_MIN &&
		exposure_out <= fsst_pkg::EXPOSURE_MAX)
		else $error("exposure out of range");
endmodule

// file: tb/tb_top.sv
/*
 Testbench: host end and device end joined by the link; register reads and
 writes on the host command port, pixel frames on the device.
 Assumes a shortened self test through the device parameter.
*/
`timescale 1ns/1ns
`define CHECK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_errors++; \
	$display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end
module tb_top;
	localparam int ST_CYC = 50;
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic pixel_valid_in = 1'b0;
	logic [7:0] pixel_level_in = 8'h00;
	logic [6:0] addr_in = 7'h00;
	logic [7:0] wdata_in = 8'h00;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [7:0] rdata_out;
	logic busy_out;
	logic done_out;
	logic selftest_busy_out;
	logic [15:0] exposure_out;
	logic [7:0] rd_val;
	int n_errors = 0;
	int num_checks = 0;
	int i;
	logic [6:0] rst_addr [11] = '{7'h07, 7'h08, 7'h09, 7'h0A, 7'h0B, 7'h0C, 7'h0D, 7'h0E, 7'h0F, 7'h10, 7'h11};
	logic [7:0] rst_val [11] = '{fsst_pkg::RST_EXPOSURE_HIGH, fsst_pkg::RST_EXPOSURE_LOW, fsst_pkg::RST_PEAK_PIXEL,
		fsst_pkg::RST_PIXEL_TOTAL, fsst_pkg::RST_LOWEST_PIXEL, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0] pass_val [4] = '{8'h18, 8'h44, 8'h62, 8'h47};
	fsst_link_if link ();
	fsst_device #(.SELFTEST_CYCLES(ST_CYC)) i_fsst_device (.clk_in(clk_in), .rst_b_in(rst_b_in), .link(link),
		.pixel_valid_in(pixel_valid_in), .pixel_level_in(pixel_level_in),
		.selftest_busy_out(selftest_busy_out), .exposure_out(exposure_out));
	fsst_host i_fsst_host (.clk_in(clk_in), .rst_b_in(rst_b_in), .link(link), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .busy_out(busy_out),
		.done_out(done_out));
	fsst_link_chk #(.SELFTEST_CYCLES(ST_CYC)) i_fsst_link_chk (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.sel_b(link.sel_b), .sclk(link.sclk), .mosi(link.mosi), .miso(link.miso),
		.selftest_busy_out(selftest_busy_out), .exposure_out(exposure_out));
	always #20 clk_in = ~clk_in;
	// ==========================================================
	// Tasks
	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic do_reset();
		rst_b_in <= 1'b0;
		repeat (10) @(posedge clk_in);
		rst_b_in <= 1'b1;
	endtask
	task automatic link_op(input logic wr, input logic [6:0] a, input logic [7:0] d);
		int k;
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= wr;
		rd_in <= !wr;
		@(posedge clk_in);
		wr_in <= 1'b0;
		rd_in <= 1'b0;
		@(posedge clk_in);
		`CHECK(busy_out, 1'b1)
		k = 0;
		while (done_out !== 1'b1 && k < 600) begin
			@(posedge clk_in);
			k++;
		end
		if (k >= 600) n_errors++;
		rd_val = rdata_out;
	endtask
	task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
		link_op(1'b0, a, 8'h00);
		`CHECK(rd_val, e)
	endtask
	// Level 0xFF stands for a clipped pixel
	task automatic send_frame(input logic [7:0] first, input logic [7:0] mid, input logic [7:0] last);
		for (int p = 0; p < fsst_pkg::PIXELS_PER_FRAME; p++) begin
			@(posedge clk_in);
			pixel_valid_in <= 1'b1;
			pixel_level_in <= (p == 0) ? first : (p == fsst_pkg::PIXELS_PER_FRAME - 1) ? last : mid;
		end
		@(posedge clk_in);
		pixel_valid_in <= 1'b0;
		repeat (4) @(posedge clk_in);
	endtask
	function automatic logic [7:0] tot(input int s);
		return ((s >> 10) > 167) ? fsst_pkg::PIXEL_TOTAL_MAX : 8'(s >> 10);
	endfunction
	// ==========================================================
	// Sequence
	initial begin
		repeat (40000) @(posedge clk_in);
		n_errors++;
		report_and_stop();
	end
	initial begin
		do_reset();
		for (i = 0; i < 11; i++) begin
			rd_chk(rst_addr[i], rst_val[i]);
		end
		link_op(1'b1, fsst_pkg::ADDR_PEAK_PIXEL, 8'h33);
		@(posedge clk_in);
		`CHECK(busy_out, 1'b0)
		rd_chk(fsst_pkg::ADDR_PEAK_PIXEL, fsst_pkg::RST_PEAK_PIXEL);
		send_frame(8'h10, 8'h80, 8'hF0);
		rd_chk(fsst_pkg::ADDR_PEAK_PIXEL, 8'hF0);
		rd_chk(fsst_pkg::ADDR_LOWEST_PIXEL, 8'h10);
		rd_chk(fsst_pkg::ADDR_PIXEL_TOTAL, tot(16 + 240 + 674 * 128));
		rd_chk(fsst_pkg::ADDR_EXPOSURE_HIGH, 8'h00);
		rd_chk(fsst_pkg::ADDR_EXPOSURE_LOW, 8'h5C);
		send_frame(8'hFF, 8'hFF, 8'hFF);
		rd_chk(fsst_pkg::ADDR_PEAK_PIXEL, 8'hFE);
		rd_chk(fsst_pkg::ADDR_LOWEST_PIXEL, 8'hFE);
		rd_chk(fsst_pkg::ADDR_PIXEL_TOTAL, tot(676 * 254));
		`CHECK(exposure_out, 16'h0054)
		// Read mid-frame must still show the previous frame
		fork
			send_frame(8'h20, 8'h20, 8'h20);
			rd_chk(fsst_pkg::ADDR_PEAK_PIXEL, 8'hFE);
		join
		rd_chk(fsst_pkg::ADDR_PIXEL_TOTAL, tot(676 * 32));
		rd_chk(fsst_pkg::ADDR_EXPOSURE_HIGH, 8'h00);
		rd_chk(fsst_pkg::ADDR_EXPOSURE_LOW, 8'h5C);
		do_reset();
		link_op(1'b1, fsst_pkg::ADDR_DIAG_START, 8'hFE);
		repeat (20) @(posedge clk_in);
		`CHECK(selftest_busy_out, 1'b0)
		link_op(1'b1, fsst_pkg::ADDR_DIAG_START, 8'h01);
		`CHECK(selftest_busy_out, 1'b1)
		i = 0;
		while (selftest_busy_out !== 1'b0 && i < 200) begin
			@(posedge clk_in);
			i++;
		end
		`CHECK(selftest_busy_out, 1'b0)
		for (i = 0; i < 4; i++) begin
			rd_chk(7'(fsst_pkg::ADDR_RESULT0 + i), pass_val[i]);
		end
		do_reset();
		for (i = 0; i < 4; i++) begin
			rd_chk(7'(fsst_pkg::ADDR_RESULT0 + i), fsst_pkg::RST_RESULT);
		end
		report_and_stop();
	end
endmodule
